// file: rtl/dodc_pkg.sv
// Shared constants for the dual output clock divider control block.
// Assumes a 32-bit classic Wishbone register bus and one system clock.
package dodc_pkg;

	// Register byte addresses
	localparam logic [3:0] DODC_OSC_ADDR  = 4'h0;
	localparam logic [3:0] DODC_DIV_ADDR  = 4'h4;
	localparam logic [3:0] DODC_MODE_ADDR = 4'h8;
	localparam logic [3:0] DODC_STAT_ADDR = 4'hc;

	// Field widths and positions
	localparam int DODC_WORD_W   = 10;
	localparam int DODC_RANGE_W  = 5;
	localparam int DODC_RANGE_LSB = 16;
	localparam int DODC_DIV_W    = 10;
	localparam int DODC_CNT_W    = 11;
	localparam int DODC_MODE_W   = 9;
	localparam int DODC_WARM_W   = 14;

	// Mode register bits
	localparam int DODC_M_BYPASS  = 0;
	localparam int DODC_M_MPRE    = 1;
	localparam int DODC_M_RPRE    = 3;
	localparam int DODC_M_EN      = 5;
	localparam int DODC_M_SEL     = 6;
	localparam int DODC_M_RPDN    = 7;
	localparam int DODC_M_MPDN    = 8;

	// Status register bits
	localparam int DODC_S_DOWN    = 0;
	localparam int DODC_S_WARM    = 1;
	localparam int DODC_S_REF_ON  = 2;
	localparam int DODC_S_MAIN_ON = 3;

	// Reset values and post-divider offset
	localparam logic [DODC_MODE_W-1:0] DODC_MODE_RST = 9'h060;
	localparam logic [DODC_DIV_W-1:0]  DODC_DIV_RST  = 10'h000;
	localparam logic [DODC_CNT_W-1:0]  DODC_DIV_OFS  = 11'h002;

	// Power sequence
	typedef enum logic [1:0] {PWR_WARM, PWR_ON, PWR_DRAIN, PWR_OFF} dodc_pwr_e;

	// Divide by 1, 2, 4 or 8 from master level and master period counter
	function automatic logic dodc_prescale(input logic [1:0] code, input logic mclk,
		input logic [2:0] mcnt);
		logic r;
		r = mclk;
		case (code)
			2'h0: r = mclk;
			2'h1: r = mcnt[0];
			2'h2: r = mcnt[1];
			default: r = mcnt[2];
		endcase
		return r;
	endfunction

endpackage

// file: rtl/dodc_top.sv
// Dual output clock divider control: prescalers, post-divider, pin modes,
// power sequencing and a Wishbone register file for the stored settings.
// Assumes clk_i is the master oscillator clock; control pins are asynchronous.
//
// What this block does
// - Reference prescaler divides master clock by 1, 2, 4 or 8.
// - Independent main prescaler divides by 1, 2, 4 or 8 into post-divider.
// - Post-divider holds 10 bits and divides by 2 up to 1025.
// - A configuration bit lets the post-divider be bypassed entirely.
// - Bypass one sends prescaler straight out; zero runs the post-divider.
// - A 10-bit oscillator control word is presented to the oscillator.
// - A range offset selects the band of the oscillator control word.
// - All settings come from stored defaults at power-up.
// - Both outputs derive synchronously from master clock, set independently.
// - Enabling is synchronised to the output clock, glitch-free, taking effect while that clock is low.
// - Disabling waits for the output to be low before floating.
// - Three stored bits choose the reference control pin role.
// - Select-only mode muxes clocks; enable mode floats on pin high.
// - All reference bits clear floats output; pin high powers down.
// - Main pin is output enable, or power-down when its bit is set.
// - Power-down requests are ORed; a pin acts when its bit is set, the reference pin also with all its bits clear.
// - Power-down disables outputs first, then stops oscillator; no programming.
// - After power-up or wake-up outputs stay off about 8000 cycles.
// - Host programs all settings; device keeps them until reprogrammed.
// - Reference output comes from a mux of master and prescaled clock.
`timescale 1ns/1ps

module dodc_top
	import dodc_pkg::*;
#(
	parameter int                       STABLE_CYCLES = 8000,
	parameter logic [DODC_WORD_W-1:0]  WORD_RST      = 10'h200,
	parameter logic [DODC_RANGE_W-1:0] RANGE_RST     = 5'h10
) (
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	input  wire logic                    wb_cyc_i,
	input  wire logic                    wb_stb_i,
	input  wire logic                    wb_we_i,
	input  wire logic [31:0]             wb_adr_i,
	input  wire logic [3:0]              wb_sel_i,
	input  wire logic [31:0]             wb_dat_i,
	output logic      [31:0]             wb_dat_o,
	output logic                         wb_ack_o,
	input  wire logic                    reference_control_pin_i,
	input  wire logic                    main_control_pin_i,
	output logic                         reference_clock_out_o,
	output logic                         reference_clock_out_oe_n_o,
	output logic                         main_clock_out_o,
	output logic                         main_clock_out_oe_n_o,
	output logic      [DODC_WORD_W-1:0]  osc_word_o,
	output logic      [DODC_RANGE_W-1:0] osc_range_o,
	output logic                         osc_run_o
);

	logic [DODC_WORD_W-1:0]  word_reg;
	logic [DODC_RANGE_W-1:0] range_reg;
	logic [DODC_DIV_W-1:0]   div_reg;
	logic [DODC_MODE_W-1:0]  mode_reg;
	logic                    ack_reg;
	logic [31:0]             rdat_reg;
	logic                    ref_s1_reg;
	logic                    ref_s2_reg;
	logic                    main_s1_reg;
	logic                    main_s2_reg;
	logic                    mclk_reg;
	logic [2:0]              mcnt_reg;
	logic                    p1_prev_reg;
	logic [DODC_CNT_W-1:0]   div_cnt_reg;
	logic                    ref_on_reg;
	logic                    main_on_reg;
	logic                    ref_out_reg;
	logic                    main_out_reg;
	logic                    ref_oe_n_reg;
	logic                    main_oe_n_reg;
	logic                    run_reg;
	logic [DODC_WARM_W-1:0]  warm_cnt_reg;
	dodc_pwr_e               state_reg;
	dodc_pwr_e               state_next;
	logic        bus_req;
	logic        wr_ok;
	logic        adr_hi_zero;
	logic [31:0] wmask;
	logic [31:0] osc_rd;
	logic [31:0] osc_wr;
	logic [31:0] div_wr;
	logic [31:0] mode_wr;
	logic        en_b;
	logic        sel_b;
	logic        rpdn_b;
	logic        mpdn_b;
	logic        bypass_b;
	logic        ref_pin;
	logic        main_pin;
	logic        p0_lvl;
	logic        p1_lvl;
	logic        ref_src;
	logic        ref_want;
	logic        main_want;
	logic        pd_req;
	logic [DODC_CNT_W-1:0] div_n;
	logic        div_hi;
	logic        main_src;

	// Bus decode and byte-lane merge
	assign bus_req     = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign adr_hi_zero = (wb_adr_i[31:4] == 28'h0000000);
	assign wr_ok       = bus_req & wb_we_i & adr_hi_zero & (state_reg != PWR_OFF);
	assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign osc_rd  = {11'h000, range_reg, 6'h00, word_reg};
	assign osc_wr  = (osc_rd & ~wmask) | (wb_dat_i & wmask);
	assign div_wr  = ({22'h000000, div_reg} & ~wmask) | (wb_dat_i & wmask);
	assign mode_wr = ({23'h000000, mode_reg} & ~wmask) | (wb_dat_i & wmask);

	// Settings restored from stored defaults on reset, kept until written
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			word_reg  <= WORD_RST;
			range_reg <= RANGE_RST;
			div_reg   <= DODC_DIV_RST;
			mode_reg  <= DODC_MODE_RST;
		end else if (wr_ok) begin
			case (wb_adr_i[3:0])
				DODC_OSC_ADDR: begin
					word_reg  <= osc_wr[DODC_WORD_W-1:0];
					range_reg <= osc_wr[DODC_RANGE_LSB +: DODC_RANGE_W];
				end
				DODC_DIV_ADDR: begin
					div_reg <= div_wr[DODC_DIV_W-1:0];
				end
				DODC_MODE_ADDR: begin
					mode_reg <= mode_wr[DODC_MODE_W-1:0];
				end
				default: ;
			endcase
		end
	end

	// Bus answer one cycle after the request; unmapped reads give zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg  <= 1'b0;
			rdat_reg <= 32'h00000000;
		end else begin
			ack_reg  <= bus_req;
			rdat_reg <= 32'h00000000;
			if (bus_req && !wb_we_i && adr_hi_zero) begin
				case (wb_adr_i[3:0])
					DODC_OSC_ADDR:  rdat_reg <= osc_rd;
					DODC_DIV_ADDR:  rdat_reg <= {22'h000000, div_reg};
					DODC_MODE_ADDR: rdat_reg <= {23'h000000, mode_reg};
					DODC_STAT_ADDR: begin
						rdat_reg[DODC_S_DOWN]    <= (state_reg == PWR_OFF);
						rdat_reg[DODC_S_WARM]    <= (state_reg == PWR_WARM);
						rdat_reg[DODC_S_REF_ON]  <= ref_on_reg;
						rdat_reg[DODC_S_MAIN_ON] <= main_on_reg;
					end
					default: rdat_reg <= 32'h00000000;
				endcase
			end
		end
	end

	// Control pin synchronisers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ref_s1_reg  <= 1'b0;
			ref_s2_reg  <= 1'b0;
			main_s1_reg <= 1'b0;
			main_s2_reg <= 1'b0;
		end else begin
			ref_s1_reg  <= reference_control_pin_i;
			ref_s2_reg  <= ref_s1_reg;
			main_s1_reg <= main_control_pin_i;
			main_s2_reg <= main_s1_reg;
		end
	end

	assign ref_pin  = ref_s2_reg;
	assign main_pin = main_s2_reg;
	assign en_b     = mode_reg[DODC_M_EN];
	assign sel_b    = mode_reg[DODC_M_SEL];
	assign rpdn_b   = mode_reg[DODC_M_RPDN];
	assign mpdn_b   = mode_reg[DODC_M_MPDN];
	assign bypass_b = mode_reg[DODC_M_BYPASS];

	// Master clock phase and period counter, frozen while the oscillator is stopped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mclk_reg <= 1'b0;
			mcnt_reg <= 3'h0;
		end else if (state_reg != PWR_OFF) begin
			mclk_reg <= ~mclk_reg;
			if (mclk_reg) begin
				mcnt_reg <= mcnt_reg + 3'h1;
			end
		end
	end

	// Prescalers and reference select mux
	assign p0_lvl = dodc_prescale(mode_reg[DODC_M_RPRE +: 2], mclk_reg, mcnt_reg);
	assign p1_lvl = dodc_prescale(mode_reg[DODC_M_MPRE +: 2], mclk_reg, mcnt_reg);

	// Reference pin role and the clock it selects
	always_comb begin
		ref_src  = sel_b ? p0_lvl : mclk_reg;
		ref_want = 1'b0;
		if (rpdn_b) begin
			ref_want = ~ref_pin;
		end else if (en_b) begin
			ref_want = ~ref_pin;
		end else if (sel_b) begin
			ref_src  = ref_pin ? p0_lvl : mclk_reg;
			ref_want = 1'b1;
		end else begin
			ref_want = 1'b0;
		end
	end

	// Power-down requests from either pin: main when its bit is set, reference when its bit is set or all its bits are clear
	assign pd_req = (ref_pin & (rpdn_b | ~(en_b | sel_b))) | (main_pin & mpdn_b);
	assign main_want = ~main_pin;

	// Post-divider counting main prescaler periods
	assign div_n  = {1'b0, div_reg} + DODC_DIV_OFS;
	assign div_hi = (div_cnt_reg < (div_n >> 1));
	assign main_src = bypass_b ? p1_lvl : div_hi;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			p1_prev_reg <= 1'b0;
			div_cnt_reg <= '0;
		end else begin
			p1_prev_reg <= p1_lvl;
			if (p1_lvl && !p1_prev_reg) begin
				if (div_cnt_reg >= div_n - DODC_CNT_W'(1)) begin
					div_cnt_reg <= '0;
				end else begin
					div_cnt_reg <= div_cnt_reg + DODC_CNT_W'(1);
				end
			end
		end
	end

	// Output enables change only while their clock is low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ref_on_reg    <= 1'b0;
			main_on_reg   <= 1'b0;
			ref_oe_n_reg  <= 1'b1;
			main_oe_n_reg <= 1'b1;
		end else begin
			if (!ref_src) begin
				ref_on_reg   <= ref_want & (state_reg == PWR_ON);
				ref_oe_n_reg <= ~(ref_want & (state_reg == PWR_ON));
			end
			if (!main_src) begin
				main_on_reg   <= main_want & (state_reg == PWR_ON);
				main_oe_n_reg <= ~(main_want & (state_reg == PWR_ON));
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ref_out_reg  <= 1'b0;
			main_out_reg <= 1'b0;
		end else begin
			ref_out_reg  <= ref_on_reg & ref_src;
			main_out_reg <= main_on_reg & main_src;
		end
	end

	// Power sequence: drain outputs, stop oscillator, warm up on wake
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			PWR_WARM: begin
				if (pd_req) begin
					state_next = PWR_OFF;
				end else if (warm_cnt_reg == DODC_WARM_W'(STABLE_CYCLES - 1)) begin
					state_next = PWR_ON;
				end
			end
			PWR_ON: begin
				if (pd_req) begin
					state_next = PWR_DRAIN;
				end
			end
			PWR_DRAIN: begin
				if (!ref_on_reg && !main_on_reg) begin
					state_next = PWR_OFF;
				end
			end
			PWR_OFF: begin
				if (!pd_req) begin
					state_next = PWR_WARM;
				end
			end
			default: state_next = PWR_WARM;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg    <= PWR_WARM;
			warm_cnt_reg <= '0;
			run_reg      <= 1'b1;
		end else begin
			state_reg <= state_next;
			run_reg   <= (state_next != PWR_OFF);
			if (state_reg == PWR_WARM) begin
				warm_cnt_reg <= warm_cnt_reg + DODC_WARM_W'(1);
			end else begin
				warm_cnt_reg <= '0;
			end
		end
	end

	assign wb_dat_o                   = rdat_reg;
	assign wb_ack_o                   = ack_reg;
	assign reference_clock_out_o      = ref_out_reg;
	assign reference_clock_out_oe_n_o = ref_oe_n_reg;
	assign main_clock_out_o           = main_out_reg;
	assign main_clock_out_oe_n_o      = main_oe_n_reg;
	assign osc_word_o                 = word_reg;
	assign osc_range_o                = range_reg;
	assign osc_run_o                  = run_reg;

	// Checks
	AST_OFF_FLOATS: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_reg == PWR_OFF) |-> (!ref_on_reg && !main_on_reg && !run_reg))
		else $error("Outputs driven or oscillator running while off");
	AST_NO_PROG_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_reg == PWR_OFF && bus_req && wb_we_i) |=> ($stable(mode_reg) && $stable(div_reg)))
		else $error("Setting changed while powered down");
	AST_WARM_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_reg == PWR_WARM) |=> (!ref_on_reg && !main_on_reg))
		else $error("Output enabled during warm-up");
	AST_WARM_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
		($past(state_reg) == PWR_WARM && state_reg == PWR_ON)
		|-> ($past(warm_cnt_reg) == DODC_WARM_W'(STABLE_CYCLES - 1)))
		else $error("Warm-up ended at wrong count");
	AST_EN_AT_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
		$changed(ref_on_reg) |-> !$past(ref_src))
		else $error("Reference enable changed while clock high");
	AST_DIS_AT_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(main_on_reg) |-> (!$past(main_src) ##1 !main_out_reg))
		else $error("Main output floated while high");
	AST_REF_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
		(!en_b && !sel_b && !rpdn_b && !ref_on_reg) |=> !ref_on_reg)
		else $error("Reference output driven with all mode bits clear");
	AST_NO_PD: assert property (@(posedge clk_i) disable iff (rst_i)
		(!rpdn_b && !mpdn_b && (en_b || sel_b)) |-> !pd_req)
		else $error("Power-down requested with both bits clear");
	AST_BYPASS: assert property (@(posedge clk_i) disable iff (rst_i)
		bypass_b && main_on_reg && $stable(p1_lvl) |=> (main_out_reg == $past(p1_lvl)))
		else $error("Bypass does not pass prescaler");
	AST_DIV_RANGE: assert property (@(posedge clk_i) disable iff (rst_i)
		$stable(div_reg) |-> (div_cnt_reg < div_n || $past(div_cnt_reg) >= div_n))
		else $error("Post-divider count out of range");
	AST_WB_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_req |=> (wb_ack_o ##1 !wb_ack_o))
		else $error("Bus answer not one cycle");
endmodule

// file: verification/dodc_host_model.sv
// Wishbone master standing in for the host that programs the settings.
// Assumes a slave answering each request with ack; the bench cuts hangs.
`timescale 1ns/1ps

module dodc_host_model (
	input  wire logic        clk_i,
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic [31:0]      adr_o,
	output logic [3:0]       sel_o,
	output logic [31:0]      dat_o,
	input  wire logic [31:0] dat_i,
	input  wire logic        ack_i
);
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 32'h0;
		sel_o = 4'h0;
		dat_o = 32'h0;
	end

	// One classic cycle; released address and data show the inverse of the last value
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		sel_o <= 4'hf;
		dat_o <= d;
		do @(posedge clk_i); while (ack_i !== 1'b1);
		q = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		we_o <= 1'b0;
		adr_o <= ~a;
		dat_o <= ~d;
	endtask
endmodule

// file: verification/dodc_top_tb.sv
// Self-checking bench for the clock divider control block.
// Assumes the host model for register access; pins driven by the bench.
`timescale 1ns/1ps

module dodc_top_tb;
	import dodc_pkg::*;
	localparam int ST = 20;
	logic        clk_i, rst_i, rpin, mpin;
	logic        cyc, stb, we, ack, rck, rck_oe_n, mck, mck_oe_n, run;
	logic [31:0] adr, wdat, rdat, q;
	logic [3:0]  sel;
	logic [9:0]  word;
	logic [4:0]  range;
	int          n_errors, tests_run, cycles, k, p;
	logic [9:0]  dv [3] = '{10'd0, 10'd1, 10'd1023};

	dodc_top #(.STABLE_CYCLES(ST)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .reference_control_pin_i(rpin),
		.main_control_pin_i(mpin), .reference_clock_out_o(rck),
		.reference_clock_out_oe_n_o(rck_oe_n), .main_clock_out_o(mck),
		.main_clock_out_oe_n_o(mck_oe_n), .osc_word_o(word), .osc_range_o(range),
		.osc_run_o(run));
	dodc_host_model host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
		.sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] x;
		host.xfer(1'b1, 32'(a), d, x);
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		host.xfer(1'b0, a, 32'h0, d);
	endtask

	function automatic logic [31:0] md(logic bp, logic [1:0] mc, logic [1:0] rc, logic en,
		logic sl, logic rp, logic mp);
		return 32'({mp, rp, sl, en, rc, mc, bp});
	endfunction

	function automatic logic pick(int w);
		return (w == 0) ? rck_oe_n : (w == 1) ? mck_oe_n : run;
	endfunction

	// Waits a bounded time for a pin-side signal, returns cycles waited
	task automatic settle(input string n, input int w, input logic v, output int c);
		c = 0;
		while (pick(w) !== v && c < 300) begin
			@(posedge clk_i);
			c++;
		end
		check(n, pick(w), v);
	endtask

	// Period of an output clock, skipping the first two periods after a change
	task automatic measure(input bit m, output int per);
		int i, r, f;
		logic pv, s;
		r = 0;
		f = 0;
		per = 0;
		pv = 1'b1;
		for (i = 0; i < 9000 && per == 0; i++) begin
			@(posedge clk_i);
			s = m ? mck : rck;
			if (s === 1'b1 && pv === 1'b0) begin
				r++;
				if (r == 3)
					f = i;
				if (r == 4)
					per = i - f;
			end
			pv = s;
		end
	endtask

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 60000) begin
			n_errors++;
			complete_run();
		end
	end

	always @(posedge clk_i) begin
		if (!rst_i) begin
			if ($fell(run))
				check("outputs off before stop", {rck_oe_n, mck_oe_n}, 2'b11);
			if ($rose(rck_oe_n) || $fell(rck_oe_n))
				check("ref low at switch", rck, 1'b0);
			if ($rose(mck_oe_n) || $fell(mck_oe_n))
				check("main low at switch", mck, 1'b0);
		end
	end

	initial begin
		n_errors = 0;
		tests_run = 0;
		cycles = 0;
		rst_i = 1'b1;
		rpin = 1'b0;
		mpin = 1'b0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		settle("warm main on", 1, 1'b0, k);
		check("warm length", k >= ST, 1'b1);
		rd(32'(DODC_OSC_ADDR), q);
		check("osc reset", q, 32'h0010_0200);
		rd(32'(DODC_MODE_ADDR), q);
		check("mode reset", q, 32'h0000_0060);
		rd(32'(DODC_DIV_ADDR), q);
		check("div reset", q, 32'h0);
		check("word reset", word, 10'h200);
		wr(DODC_OSC_ADDR, 32'h0005_0155);
		check("word", word, 10'h155);
		check("range", range, 5'h05);
		wr(DODC_STAT_ADDR, 32'hffff_ffff);
		rd(32'h10, q);
		check("unmapped", q, 32'h0);
		rd(32'(DODC_OSC_ADDR), q);
		check("osc kept", q, 32'h0005_0155);
		for (int c = 0; c < 4; c++) begin
			wr(DODC_MODE_ADDR, md(1, 2'(3 - c), 2'(c), 1, 1, 0, 0));
			measure(0, p);
			check("ref period", p, 2 << c);
			measure(1, p);
			check("bypass period", p, 2 << (3 - c));
		end
		wr(DODC_MODE_ADDR, md(0, 0, 0, 1, 1, 0, 0));
		foreach (dv[i]) begin
			wr(DODC_DIV_ADDR, 32'(dv[i]));
			measure(1, p);
			check("post div period", p, 2 * (dv[i] + 2));
		end
		wr(DODC_MODE_ADDR, md(1, 0, 2, 0, 1, 0, 0));
		measure(0, p);
		check("mux low", p, 2);
		rpin <= 1'b1;
		measure(0, p);
		check("mux high", p, 8);
		check("mux no shutdown", run, 1'b1);
		wr(DODC_MODE_ADDR, md(1, 0, 2, 1, 0, 0, 0));
		settle("enable mode off", 0, 1'b1, k);
		rpin <= 1'b0;
		measure(0, p);
		check("enable mode on", p, 2);
		mpin <= 1'b1;
		settle("main pin off", 1, 1'b1, k);
		check("main oe no shutdown", run, 1'b1);
		mpin <= 1'b0;
		wr(DODC_MODE_ADDR, md(1, 0, 0, 0, 0, 0, 0));
		settle("all clear floats", 0, 1'b1, k);
		rpin <= 1'b1;
		settle("all clear down", 2, 1'b0, k);
		rpin <= 1'b0;
		settle("wake main on", 1, 1'b0, k);
		check("wake length", k >= ST, 1'b1);
		wr(DODC_MODE_ADDR, md(1, 0, 1, 0, 1, 1, 0));
		measure(0, p);
		check("ref pdn drives", p, 4);
		rpin <= 1'b1;
		settle("ref pdn down", 2, 1'b0, k);
		wr(DODC_DIV_ADDR, 32'h5);
		rd(32'(DODC_STAT_ADDR), q);
		check("status down", q[DODC_S_DOWN], 1'b1);
		rpin <= 1'b0;
		settle("ref pdn wake", 1, 1'b0, k);
		rd(32'(DODC_DIV_ADDR), q);
		check("no program while down", q, 32'd1023);
		wr(DODC_MODE_ADDR, md(1, 0, 0, 1, 1, 0, 1));
		mpin <= 1'b1;
		settle("main pdn down", 2, 1'b0, k);
		mpin <= 1'b0;
		settle("main pdn wake", 2, 1'b1, k);
		complete_run();
	end
endmodule
